// ==== inc/ext_access_pkg.sv ====
/*
  Constants, types and register map of the external access mode control.
  Assumes one 20 MHz clock, a synchronous reset and an APB register port.
*/
package ext_access_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 50;
  localparam int INSTR_CYCLE_NS = 160;
  localparam int INSTR_CYCLES   = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] STEP_LAST = 3'(INSTR_CYCLES - 1);

  // ****************************************
  // Access mode register fields
  // ****************************************
  localparam int AMR_W      = 7;
  localparam int AMR_SPEED  = 0;
  localparam int AMR_PSEUDO = 1;
  localparam int AMR_JOINED = 2;
  localparam int AMR_STROBE = 3;
  localparam int AMR_SIX    = 4;
  localparam int AMR_FIVE   = 5;
  localparam int AMR_MASK   = 6;
  localparam logic [6:0] AMR_RESET = 7'h34;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_AMR    = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_LOOP   = 8'h0C;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_INSTR  = 8'h14;
  localparam logic [7:0] OFF_PTR    = 8'h18;
  localparam int         PTR_REGS   = 6;

  // Control register fields.
  localparam int CTRL_SAT   = 2;
  localparam int CTRL_RING  = 3;
  localparam int CTRL_PAIR  = 5;
  localparam int CTRL_EMPTY = 7;
  // Status register fields.
  localparam int ST_OVF     = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] NOP_INSTR = 32'h0000_0000;
  localparam int PTR_W = 7;

  typedef enum logic [1:0] {
    MODE_REAL    = 2'b00,
    MODE_COMPLEX = 2'b01,
    MODE_DOUBLE  = 2'b10
  } mode_t;

  typedef enum logic {
    ACC_IDLE = 1'b0,
    ACC_BUSY = 1'b1
  } acc_state_t;

  typedef struct packed {
    logic        write;
    logic [11:0] addr;
    logic [15:0] wdata;
  } acc_req_t;

endpackage

// ==== verilog/ext_access_ctrl.sv ====
/*
  External access mode control: access mode register, reset and halt
  effects, sequencer counters, circular pointer aliasing, pair ordering
  and the local and system bus access engine with an APB register port.
  Assumes all inputs synchronous to clk_sys and an APB master.
*/
// Behaviour
// - Seven-bit access mode register, written and read back by software.
// - Bit 0 clear: access lasts one instruction cycle; set: two.
// - Slow exchange repeats the instruction defining the transfer.
// - Pseudo-slave drives system bus lines as local RAM address.
// - Pseudo-slave hands the system bus over when the master asks.
// - Bit 2 clear: two byte lanes; set: one sixteen-bit bus.
// - Bit 3 clear: read and write pulses; set: strobe plus direction.
// - Bit 4 clear: shared pin is transfer acknowledge; set: test input.
// - Bit 5 clear: shared pin shows bus available; set: test input.
// - Mask set forces fast, pseudo-slave, joined, pulses under halt.
// - Mask bit stays writable while halt is asserted.
// - Reset: fast, slave, joined, pulses, both shared pins test inputs.
// - Reset clears program and loop counters and loads a no-operation.
// - Reset: real mode, no saturation, FIFO empty set, overflow cleared.
// - Halt freezes counters and lets the instruction load externally.
// - Four select lines, extended to twelve address bits for memory.
// - Separate bus: low lane only when top address bits are zero.
// - In circular mode the lower-limit pointer aliases the current one.
// - Per-RAM circular flag shows circular mode in status.
// - Complex or double modes issue even then odd, reversed by pair bit.
module ext_access_ctrl
  import ext_access_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_halt,
  input  wire logic        ext_instr_valid,
  input  wire logic [31:0] ext_instr,
  input  wire logic [31:0] instr_fetch,
  input  wire logic        ovf_event,
  input  wire logic        fifo_push,
  input  wire logic        fifo_drain,
  input  wire logic        acc_valid,
  input  wire acc_req_t    acc_req,
  output logic             acc_taken,
  output logic             acc_done,
  output logic      [15:0] acc_rdata,
  input  wire logic        master_bus_req,
  output logic             bus_granted,
  output logic      [3:0]  peripheral_select_lines,
  output logic      [7:0]  system_bus_lines_out,
  output logic             system_bus_lines_oe,
  input  wire logic [15:0] local_data_lines_in,
  output logic      [15:0] local_data_lines_out,
  output logic      [1:0]  local_data_lines_oe,
  output logic             rd_n,
  output logic             wr_n,
  output logic             transfer_strobe_n,
  output logic             rw_dir,
  input  wire logic        ack_six_in,
  output logic             ack_six_out,
  output logic             ack_six_oe,
  input  wire logic        avail_five_in,
  output logic             avail_five_out,
  output logic             avail_five_oe,
  output logic             instr_step,
  output logic      [31:0] instruction_out,
  output logic      [PTR_W-1:0] ram_addr_first,
  output logic      [PTR_W-1:0] ram_addr_second
);

  // ****************************************
  // Core state
  // ****************************************
  logic [6:0]        access_mode_reg,   access_mode_next;
  mode_t             mode_reg,          mode_next;
  logic              sat_reg,           sat_next;
  logic [1:0]        ring_reg,          ring_next;
  logic [1:0]        pair_order_reg,    pair_order_next;
  logic              fifo_empty_reg,    fifo_empty_next;
  logic              sticky_ovf_reg,    sticky_ovf_next;
  logic [1:0]        ext_test_reg,      ext_test_next;
  logic [15:0]       pc_reg,            pc_next;
  logic [15:0]       loop_counter_reg,  loop_counter_next;
  logic [31:0]       instruction_reg,   instruction_next;
  logic              phase_reg,         phase_next;
  logic [2:0]        step_cnt_reg,      step_cnt_next;
  logic              step_reg,          step_next;
  logic [PTR_W-1:0]  ptr_reg [PTR_REGS], ptr_next [PTR_REGS];
  logic [PTR_W-1:0]  addr_reg [2],      addr_next [2];
  logic [31:0]       prdata_reg,        prdata_next;
  logic              pready_reg,        pready_next;
  logic              pslverr_reg,       pslverr_next;
  logic              repeat_reg;

  logic              wr_en;
  logic              setup;
  logic              mapped;
  logic [7:0]        rel;
  logic [2:0]        pidx;
  logic [2:0]        widx;
  logic [PTR_W-1:0]  base;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_reg & pwrite;
  assign rel   = paddr - OFF_PTR;
  assign pidx  = rel[4:2];

  always_comb begin
    access_mode_next  = access_mode_reg;
    mode_next         = mode_reg;
    sat_next          = sat_reg;
    ring_next         = ring_reg;
    pair_order_next   = pair_order_reg;
    fifo_empty_next   = fifo_empty_reg;
    sticky_ovf_next   = sticky_ovf_reg;
    pc_next           = pc_reg;
    loop_counter_next = loop_counter_reg;
    instruction_next  = instruction_reg;
    phase_next        = phase_reg;
    prdata_next       = 32'h0000_0000;
    pready_next       = setup;
    mapped            = 1'b1;
    widx              = 3'h0;
    base              = '0;
    for (int i = 0; i < PTR_REGS; i++) begin
      ptr_next[i] = ptr_reg[i];
    end
    // Shared pins sample the test conditions only when redefined as inputs.
    ext_test_next = {access_mode_reg[AMR_FIVE] & avail_five_in,
                     access_mode_reg[AMR_SIX] & ack_six_in};
    step_next     = (step_cnt_reg == STEP_LAST);
    step_cnt_next = step_next ? 3'h0 : step_cnt_reg + 3'h1;

    if (wr_en) begin
      unique case (paddr)
        OFF_AMR:    access_mode_next = pwdata[6:0];
        OFF_CTRL: begin
          mode_next       = mode_t'(pwdata[1:0]);
          sat_next        = pwdata[CTRL_SAT];
          ring_next       = pwdata[CTRL_RING +: 2];
          pair_order_next = pwdata[CTRL_PAIR +: 2];
          if (pwdata[CTRL_EMPTY]) begin
            fifo_empty_next = 1'b1;
          end
        end
        OFF_STATUS: begin
          if (pwdata[ST_OVF]) begin
            sticky_ovf_next = 1'b0;
          end
        end
        OFF_LOOP:   loop_counter_next = pwdata[15:0];
        default: begin
          if (paddr >= OFF_PTR && rel < 8'(4 * PTR_REGS) && paddr[1:0] == 2'b00) begin
            widx = pidx;
            // A lower-limit write in circular mode lands on the current pointer.
            if (pidx % 3 == 0 && ring_reg[pidx / 3]) begin
              widx = pidx + 3'h2;
            end
            ptr_next[widx] = pwdata[PTR_W-1:0];
          end
        end
      endcase
    end

    if (ovf_event) begin
      sticky_ovf_next = 1'b1;
    end
    if (fifo_push && !fifo_drain) begin
      fifo_empty_next = 1'b0;
    end
    if (fifo_drain) begin
      fifo_empty_next = 1'b1;
    end

    if (ext_halt) begin
      if (ext_instr_valid) begin
        instruction_next = ext_instr;
      end
      if (access_mode_next[AMR_MASK]) begin
        access_mode_next[AMR_SPEED]  = 1'b0;
        access_mode_next[AMR_PSEUDO] = 1'b1;
        access_mode_next[AMR_JOINED] = 1'b1;
        access_mode_next[AMR_STROBE] = 1'b0;
      end
    end else if (step_reg && !repeat_reg) begin
      // Halt leaves the counters frozen; a repeated step does not advance.
      if (mode_reg != MODE_REAL && !phase_reg) begin
        phase_next = 1'b1;
      end else begin
        phase_next       = 1'b0;
        pc_next          = pc_reg + 16'h0001;
        instruction_next = instr_fetch;
        if (loop_counter_reg != 16'h0000 && !(wr_en && paddr == OFF_LOOP)) begin
          loop_counter_next = loop_counter_reg - 16'h0001;
        end
      end
    end

    for (int g = 0; g < 2; g++) begin
      base = ring_reg[g] ? ptr_reg[3 * g + 2] : ptr_reg[3 * g];
      if (mode_reg == MODE_REAL) begin
        addr_next[g] = base;
      end else begin
        addr_next[g] = {base[PTR_W-1:1], phase_reg ^ pair_order_reg[g]};
      end
    end

    if (setup) begin
      unique case (paddr)
        OFF_AMR:    prdata_next = {25'h0, access_mode_reg};
        OFF_CTRL:   prdata_next = {24'h0, 1'b0, pair_order_reg, ring_reg, sat_reg, mode_reg};
        OFF_STATUS: prdata_next = {24'h0, ext_test_reg, ext_halt, ring_reg, sat_reg,
                                   fifo_empty_reg, sticky_ovf_reg};
        OFF_LOOP:   prdata_next = {16'h0, loop_counter_reg};
        OFF_PC:     prdata_next = {16'h0, pc_reg};
        OFF_INSTR:  prdata_next = instruction_reg;
        default: begin
          if (paddr >= OFF_PTR && rel < 8'(4 * PTR_REGS) && paddr[1:0] == 2'b00) begin
            widx = pidx;
            if (pidx % 3 == 0 && ring_reg[pidx / 3]) begin
              widx = pidx + 3'h2;
            end
            prdata_next = {25'h0, ptr_reg[widx]};
          end else begin
            mapped = 1'b0;
          end
        end
      endcase
    end else begin
      mapped = 1'b1;
    end
    pslverr_next = setup & ~mapped;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      access_mode_reg  <= AMR_RESET;
      mode_reg         <= MODE_REAL;
      sat_reg          <= 1'b0;
      ring_reg         <= 2'b00;
      pair_order_reg   <= 2'b00;
      fifo_empty_reg   <= 1'b1;
      sticky_ovf_reg   <= 1'b0;
      ext_test_reg     <= 2'b00;
      pc_reg           <= 16'h0000;
      loop_counter_reg <= 16'h0000;
      instruction_reg  <= NOP_INSTR;
      phase_reg        <= 1'b0;
      step_cnt_reg     <= 3'h0;
      step_reg         <= 1'b0;
      prdata_reg       <= 32'h0000_0000;
      pready_reg       <= 1'b0;
      pslverr_reg      <= 1'b0;
      for (int i = 0; i < PTR_REGS; i++) begin
        ptr_reg[i] <= '0;
      end
      for (int g = 0; g < 2; g++) begin
        addr_reg[g] <= '0;
      end
    end else begin
      access_mode_reg  <= access_mode_next;
      mode_reg         <= mode_next;
      sat_reg          <= sat_next;
      ring_reg         <= ring_next;
      pair_order_reg   <= pair_order_next;
      fifo_empty_reg   <= fifo_empty_next;
      sticky_ovf_reg   <= sticky_ovf_next;
      ext_test_reg     <= ext_test_next;
      pc_reg           <= pc_next;
      loop_counter_reg <= loop_counter_next;
      instruction_reg  <= instruction_next;
      phase_reg        <= phase_next;
      step_cnt_reg     <= step_cnt_next;
      step_reg         <= step_next;
      prdata_reg       <= prdata_next;
      pready_reg       <= pready_next;
      pslverr_reg      <= pslverr_next;
      for (int i = 0; i < PTR_REGS; i++) begin
        ptr_reg[i] <= ptr_next[i];
      end
      for (int g = 0; g < 2; g++) begin
        addr_reg[g] <= addr_next[g];
      end
    end
  end

  // ****************************************
  // External access engine
  // ****************************************
  acc_state_t  acc_state_reg,  acc_state_next;
  acc_req_t    held_reg,       held_next;
  logic        left_reg,       left_next;
  logic        repeat_next;
  logic        taken_reg,      taken_next;
  logic        done_reg,       done_next;
  logic [15:0] rdata_reg,      rdata_next;
  logic        grant_reg,      grant_next;
  logic        low_lane;
  logic        pseudo;
  logic        busy;
  logic        sys_free;
  logic [1:0]  lane_oe;

  assign pseudo   = access_mode_reg[AMR_PSEUDO];
  assign sys_free = !(pseudo && master_bus_req);
  assign low_lane = (held_reg.addr[11:10] == 2'b00);

  always_comb begin
    acc_state_next = acc_state_reg;
    held_next      = held_reg;
    left_next      = left_reg;
    repeat_next    = repeat_reg;
    taken_next     = 1'b0;
    done_next      = 1'b0;
    rdata_next     = rdata_reg;
    if (step_reg) begin
      unique case (acc_state_reg)
        ACC_IDLE: begin
          repeat_next = 1'b0;
          if (acc_valid && !ext_halt && sys_free) begin
            acc_state_next = ACC_BUSY;
            held_next      = acc_req;
            left_next      = access_mode_reg[AMR_SPEED];
            repeat_next    = access_mode_reg[AMR_SPEED];
            taken_next     = 1'b1;
          end
        end
        ACC_BUSY: begin
          if (left_reg) begin
            left_next   = 1'b0;
            repeat_next = 1'b0;
          end else begin
            acc_state_next = ACC_IDLE;
            done_next      = 1'b1;
            if (!held_reg.write) begin
              if (access_mode_reg[AMR_JOINED]) begin
                rdata_next = local_data_lines_in;
              end else if (low_lane) begin
                rdata_next = {8'h00, local_data_lines_in[7:0]};
              end else begin
                rdata_next = {8'h00, local_data_lines_in[15:8]};
              end
            end
          end
        end
      endcase
    end
    busy       = (acc_state_next == ACC_BUSY);
    grant_next = master_bus_req && !(pseudo && busy);
    if (access_mode_reg[AMR_JOINED]) begin
      lane_oe = 2'b11;
    end else begin
      lane_oe = (held_next.addr[11:10] == 2'b00) ? 2'b01 : 2'b10;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_state_reg           <= ACC_IDLE;
      held_reg                <= '0;
      left_reg                <= 1'b0;
      repeat_reg              <= 1'b0;
      taken_reg               <= 1'b0;
      done_reg                <= 1'b0;
      rdata_reg               <= 16'h0000;
      grant_reg               <= 1'b0;
      peripheral_select_lines <= 4'h0;
      system_bus_lines_out    <= 8'h00;
      system_bus_lines_oe     <= 1'b0;
      local_data_lines_out    <= 16'h0000;
      local_data_lines_oe     <= 2'b00;
      rd_n                    <= 1'b1;
      wr_n                    <= 1'b1;
      transfer_strobe_n       <= 1'b1;
      rw_dir                  <= 1'b1;
      ack_six_out             <= 1'b0;
      ack_six_oe              <= 1'b0;
      avail_five_out          <= 1'b0;
      avail_five_oe           <= 1'b0;
    end else begin
      acc_state_reg           <= acc_state_next;
      held_reg                <= held_next;
      left_reg                <= left_next;
      repeat_reg              <= repeat_next;
      taken_reg               <= taken_next;
      done_reg                <= done_next;
      rdata_reg               <= rdata_next;
      grant_reg               <= grant_next;
      peripheral_select_lines <= held_next.addr[11:8];
      system_bus_lines_out    <= held_next.addr[7:0];
      system_bus_lines_oe     <= busy && pseudo;
      local_data_lines_out    <= access_mode_reg[AMR_JOINED] ? held_next.wdata
                                 : {2{held_next.wdata[7:0]}};
      local_data_lines_oe     <= (busy && held_next.write) ? lane_oe : 2'b00;
      rd_n              <= !(busy && !held_next.write && !access_mode_reg[AMR_STROBE]);
      wr_n              <= !(busy && held_next.write && !access_mode_reg[AMR_STROBE]);
      transfer_strobe_n <= !(busy && access_mode_reg[AMR_STROBE]);
      rw_dir            <= !(busy && held_next.write && access_mode_reg[AMR_STROBE]);
      ack_six_out             <= done_next;
      ack_six_oe              <= !access_mode_reg[AMR_SIX];
      avail_five_out          <= !(busy && pseudo);
      avail_five_oe           <= !access_mode_reg[AMR_FIVE];
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign acc_taken       = taken_reg;
  assign acc_done        = done_reg;
  assign acc_rdata       = rdata_reg;
  assign bus_granted     = grant_reg;
  assign instr_step      = step_reg;
  assign instruction_out = instruction_reg;
  assign ram_addr_first  = addr_reg[0];
  assign ram_addr_second = addr_reg[1];

endmodule

// ==== test/ext_access_chk.sv ====
/*
  Port assertions of the external access mode control.
  Assumes it is bound into ext_access_ctrl on one clock.
*/
module ext_access_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       acc_taken,
  input wire logic       acc_done,
  input wire logic [3:0] peripheral_select_lines,
  input wire logic       system_bus_lines_oe,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       transfer_strobe_n,
  input wire logic       rw_dir,
  input wire logic       ack_six_out,
  input wire logic       ack_six_oe,
  input wire logic       avail_five_oe,
  input wire logic       instr_step
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  pready_timing_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  done_latency_a: assert property (acc_taken |-> (##4 acc_done) or (##8 acc_done))
    else $error("access length wrong");
  addr_hold_a: assert property (!acc_taken && !acc_done && !(rd_n && wr_n && transfer_strobe_n)
    |-> $stable(peripheral_select_lines) && $stable(rw_dir))
    else $error("address moved during access");
  ack_pin_a: assert property (ack_six_oe |-> ack_six_out == acc_done)
    else $error("acknowledge pin wrong");
  sysbus_drive_a: assert property ($rose(system_bus_lines_oe) |-> acc_taken)
    else $error("system bus driven outside access");
  strobe_style_a: assert property (!((!rd_n || !wr_n) && !transfer_strobe_n) && (rd_n || wr_n))
    else $error("strobe styles mixed");
  reset_state_a: assert property ($fell(rst) |-> !pready && rd_n && wr_n && !ack_six_oe
    && !avail_five_oe)
    else $error("reset state wrong");
  step_period_a: assert property (instr_step |=> !instr_step [*3] ##1 instr_step)
    else $error("instruction cycle not four clocks");
endmodule

bind ext_access_ctrl ext_access_chk u_chk (.clk_sys, .rst, .psel, .penable, .pready, .pslverr,
  .acc_taken, .acc_done, .peripheral_select_lines, .system_bus_lines_oe, .rd_n, .wr_n,
  .transfer_strobe_n, .rw_dir, .ack_six_out, .ack_six_oe, .avail_five_oe, .instr_step);

// ==== test/local_mem_model.sv ====
/*
  Memory or peripheral on the local bus, sixteen words by select lines.
  Assumes the bench ties it to the design's local bus pins.
*/
module local_mem_model (
  input wire logic        clk_sys,
  input wire logic [3:0]  sel,
  input wire logic [15:0] d_out,
  input wire logic [1:0]  oe,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        ts_n,
  input wire logic        rw_dir,
  output logic     [15:0] d_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  wire rd_act = !rd_n || (!ts_n && rw_dir);
  wire wr_act = !wr_n || (!ts_n && !rw_dir);
  always_ff @(posedge clk_sys) begin
    if (wr_act && oe[0]) mem[sel][7:0] <= d_out[7:0];
    if (wr_act && oe[1]) mem[sel][15:8] <= d_out[15:8];
    last <= d_in;
  end
  // Released lines show a changing pattern, never the last value.
  assign d_in = rd_act ? mem[sel] : ~last;
endmodule

// ==== test/dsp_external_access_mode_control_tb.sv ====
/*
  Self-checking bench of the external access mode control.
  Assumes the design package, the checker and the local memory model.
*/
module dsp_external_access_mode_control_tb;
  import ext_access_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ext_halt = 1;
  logic ext_instr_valid = 0, ovf_event = 0, fifo_push = 0, acc_valid = 0, master_bus_req = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, ext_instr = 0, prdata, rdat;
  acc_req_t acc_req = '0;
  logic pready, pslverr, acc_taken, acc_done, bus_granted, system_bus_lines_oe, rd_n, wr_n;
  logic transfer_strobe_n, rw_dir, ack_six_out, ack_six_oe, avail_five_out, avail_five_oe;
  logic instr_step, rerr, saw_ds, saw_sb;
  logic [15:0] acc_rdata, local_data_lines_in, local_data_lines_out, d;
  logic [3:0] peripheral_select_lines;
  logic [7:0] system_bus_lines_out;
  logic [1:0] local_data_lines_oe, oe_seen;
  logic [2:0] c;
  wire ack_six_in = ack_six_oe ? ack_six_out : 1'b1;
  wire avail_five_in = avail_five_oe ? avail_five_out : 1'b0;
  int num_errors = 0, samples_checked = 0, t;
  initial forever #25 clk_sys = ~clk_sys;
  ext_access_ctrl u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_halt, .ext_instr_valid, .ext_instr, .instr_fetch(32'h0000_0000),
    .ovf_event, .fifo_push, .fifo_drain(1'b0), .acc_valid, .acc_req, .acc_taken, .acc_done,
    .acc_rdata, .master_bus_req, .bus_granted, .peripheral_select_lines, .system_bus_lines_out,
    .system_bus_lines_oe, .local_data_lines_in, .local_data_lines_out, .local_data_lines_oe,
    .rd_n, .wr_n, .transfer_strobe_n, .rw_dir, .ack_six_in, .ack_six_out, .ack_six_oe,
    .avail_five_in, .avail_five_out, .avail_five_oe, .instr_step, .instruction_out(),
    .ram_addr_first(), .ram_addr_second());
  local_mem_model u_mem (.clk_sys, .sel(peripheral_select_lines), .d_out(local_data_lines_out),
    .oe(local_data_lines_oe), .rd_n, .wr_n, .ts_n(transfer_strobe_n), .rw_dir,
    .d_in(local_data_lines_in));
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bound(input int n);
    if (n > 60) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      bound(n++);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(0, a, 0);
    chk(nm, rdat & m, e);
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] wd);
    @(posedge clk_sys);
    acc_valid <= 1;
    acc_req <= '{w, a, wd};
    t = 0;
    do begin
      @(posedge clk_sys);
      bound(t++);
    end while (acc_taken !== 1'b1);
    acc_valid <= 0;
    {t, saw_ds, saw_sb, oe_seen} = 0;
    do begin
      @(posedge clk_sys);
      bound(t++);
      saw_ds |= !transfer_strobe_n;
      saw_sb |= system_bus_lines_oe;
      oe_seen |= local_data_lines_oe;
    end while (acc_done !== 1'b1);
  endtask
  initial begin
    rdat = $urandom(29);
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    rchk("amr", OFF_AMR, 32'h7F, 32'h34);
    rchk("status", OFF_STATUS, 32'hFF, 32'h62);
    for (int i = 1; i < 6; i++) rchk("zero", 8'(4 * i + (i > 1 ? 4 : 0)), '1, 0);
    ext_instr <= $urandom;
    ext_instr_valid <= 1;
    @(posedge clk_sys);
    ext_instr_valid <= 0;
    rchk("instr", OFF_INSTR, '1, ext_instr);
    apb(1, OFF_AMR, 32'h40);
    rchk("amr_forced", OFF_AMR, 32'h7F, 32'h46);
    apb(1, OFF_AMR, 32'h01);
    rchk("mask_clear", OFF_AMR, 32'h40, 0);
    ext_halt <= 0;
    ovf_event <= 1;
    fifo_push <= 1;
    @(posedge clk_sys);
    {ovf_event, fifo_push} <= 0;
    rchk("flags", OFF_STATUS, 32'h3, 32'h1);
    apb(1, 8'h04, 32'h08);
    rchk("ring_flag", OFF_STATUS, 32'h18, 32'h08);
    d = 16'($urandom & 16'h7F);
    apb(1, 8'h18, {16'h0000, d});
    rchk("ring_alias", 8'h20, 32'h7F, {16'h0000, d});
    apb(0, 8'h3C, 0);
    chk("unmapped", rerr, 1);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      apb(1, OFF_AMR, {25'h0, 1'b0, c[1], c[0], c[1], ~c[2], c[0] ^ c[1], c[0]});
      rchk("amr_rw", OFF_AMR, 32'h7F, {25'h0, 1'b0, c[1], c[0], c[1], ~c[2], c[0] ^ c[1], c[0]});
      d = 16'($urandom);
      rdat[11:0] = {4'($urandom), 8'h00};
      acc(1, rdat[11:0], d);
      chk("length", t, c[0] ? 8 : 4);
      chk("strobe_kind", saw_ds, c[1]);
      chk("sysbus_oe", saw_sb, c[0] ^ c[1]);
      chk("lanes", oe_seen, c[2] ? (rdat[11:10] == 0 ? 2'b01 : 2'b10) : 2'b11);
      acc(0, rdat[11:0], 0);
      chk("rdata", c[2] ? acc_rdata[7:0] : acc_rdata, c[2] ? d[7:0] : d);
    end
    apb(1, OFF_AMR, 32'h36);
    master_bus_req <= 1;
    acc_valid <= 1;
    {t, saw_ds} = 0;
    repeat (12) begin
      @(posedge clk_sys);
      saw_ds |= acc_taken;
    end
    chk("refused", saw_ds, 0);
    chk("granted", bus_granted, 1);
    {master_bus_req, acc_valid} <= 0;
    complete_run();
  end
endmodule
